// *** hw/tpg_params.svh ***
// Purpose: Constants for the test-pattern frame timing block.
// Assumes: Indirect registers are byte wide, reached by offset and data.
// Notes:   Two output ports each own a copy of the timing registers.
//
// Contract
// - Total width bits 7:0 come from total_width_low.
// - Total width bits 11:8 come from low nibble of offset 0x5.
// - Total height bits 3:0 come from high nibble of offset 0x5.
// - Total height bits 11:4 come from total_height_high.
// - Active width bits 7:0 come from active_width_low.
// - Active width bits 11:8 come from low nibble of offset 0x8.
// - Active height bits 3:0 come from high nibble of offset 0x8.
// - Active height bits 11:4 come from active_height_high.
// - Hsync pulse lasts hsync_width_setting pixels, software uses 1 to 255.
// - Vsync pulse lasts vsync_width_setting lines, software uses 1 to 255.
// - Back porch lasts hback_porch_setting pixels, software uses 1 to 255.
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH
`define TPG_OFS_TWL    8'h04
`define TPG_OFS_THLWH  8'h05
`define TPG_OFS_THH    8'h06
`define TPG_OFS_AWL    8'h07
`define TPG_OFS_AHLWH  8'h08
`define TPG_OFS_AHH    8'h09
`define TPG_OFS_HSW    8'h0A
`define TPG_OFS_VSW    8'h0B
`define TPG_OFS_HBP    8'h0C
`define TPG_OFS_VBP    8'h0D
`define TPG_RST_TWL    8'h48
`define TPG_RST_THLWH  8'h53
`define TPG_RST_THH    8'h1E
`define TPG_RST_AWL    8'h20
`define TPG_RST_AHLWH  8'h03
`define TPG_RST_AHH    8'h1E
`define TPG_RST_HSW    8'h0A
`define TPG_RST_VSW    8'h02
`define TPG_RST_HBP    8'h0A
`define TPG_RST_VBP    8'h02
`define TPG_NREG       10
`define TPG_NPORT      2
`define TPG_ONE12      12'h001
`define TPG_ZERO12     12'h000
`endif

// *** hw/tpg_pkg.sv ***
// Purpose: Types shared by the test-pattern frame timing block.
// Assumes: Nothing beyond the constants header.
// Notes:   Raster phase states are one-hot.
package tpg_pkg;
   typedef logic [11:0] tpg_dim_t;
   typedef logic [7:0]  tpg_byte_t;
   typedef enum logic [1:0] {
      TPG_OFF = 2'b01,
      TPG_RUN = 2'b10
   } tpg_state_e;
endpackage

// *** hw/tpg_frame_timing.sv ***
// Purpose: Indirect timing registers and raster timing of the generator.
// Assumes: Port select, offset and data strobes come from the main
//          register space on this clock.
// Notes:   Timing is latched whole at each frame start while enabled.
`timescale 1ns/1ps
`include "tpg_params.svh"
module tpg_frame_timing
   import tpg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] port_sel,
   input  wire logic [7:0] indirect_offset_reg,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wdata,
   output logic      [7:0] indirect_data_reg,
   input  wire logic       gen_enable,
   output logic            hsync,
   output logic            vsync,
   output logic            hblank,
   output logic            vblank,
   output logic            de,
   output logic      [11:0] pix_x,
   output logic      [11:0] line_y
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] ofs_index(input logic [7:0] ofs);
      logic [7:0] d;
      d = ofs - `TPG_OFS_TWL;
      ofs_index = d[3:0];
   endfunction

   function automatic logic ofs_hit(input logic [7:0] ofs);
      ofs_hit = (ofs >= `TPG_OFS_TWL) && (ofs <= `TPG_OFS_VBP);
   endfunction

   function automatic tpg_byte_t reg_reset(input int i);
      case (i)
         0: reg_reset = `TPG_RST_TWL;
         1: reg_reset = `TPG_RST_THLWH;
         2: reg_reset = `TPG_RST_THH;
         3: reg_reset = `TPG_RST_AWL;
         4: reg_reset = `TPG_RST_AHLWH;
         5: reg_reset = `TPG_RST_AHH;
         6: reg_reset = `TPG_RST_HSW;
         7: reg_reset = `TPG_RST_VSW;
         8: reg_reset = `TPG_RST_HBP;
         default: reg_reset = `TPG_RST_VBP;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register bank, one copy per output port; raster uses port 0 copy.
   tpg_byte_t regs      [`TPG_NPORT][`TPG_NREG];
   tpg_byte_t next_regs [`TPG_NPORT][`TPG_NREG];
   tpg_byte_t next_rdata;

   always_comb begin
      next_regs  = regs;
      next_rdata = 8'h00;
      for (int p = 0; p < `TPG_NPORT; p++) begin
         if (port_sel[p] && data_wr && ofs_hit(indirect_offset_reg)) begin
            next_regs[p][ofs_index(indirect_offset_reg)] = data_wdata;
         end
      end
      // Reads return the lowest selected port; unmapped offsets read zero.
      if (ofs_hit(indirect_offset_reg)) begin
         if (port_sel[0]) begin
            next_rdata = regs[0][ofs_index(indirect_offset_reg)];
         end else if (port_sel[1]) begin
            next_rdata = regs[1][ofs_index(indirect_offset_reg)];
         end
      end
   end

   generate
      for (genvar gp = 0; gp < `TPG_NPORT; gp++) begin : g_port
         for (genvar gr = 0; gr < `TPG_NREG; gr++) begin : g_reg
            always_ff @(posedge clk or negedge rstn) begin
               if (!rstn) begin
                  regs[gp][gr] <= reg_reset(gr);
               end else begin
                  regs[gp][gr] <= next_regs[gp][gr];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         indirect_data_reg <= 8'h00;
      end else begin
         indirect_data_reg <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assembled dimensions from the live register bytes.
   tpg_dim_t frame_total_width;
   tpg_dim_t frame_total_height;
   tpg_dim_t active_region_width;
   tpg_dim_t active_region_height;
   tpg_byte_t hsync_width_setting;
   tpg_byte_t vsync_width_setting;
   tpg_byte_t hback_porch_setting;
   tpg_byte_t vback_porch_setting;

   always_comb begin
      frame_total_width[7:0]     = regs[0][0];
      frame_total_width[11:8]    = regs[0][1][3:0];
      frame_total_height[3:0]    = regs[0][1][7:4];
      frame_total_height[11:4]   = regs[0][2];
      active_region_width[7:0]   = regs[0][3];
      active_region_width[11:8]  = regs[0][4][3:0];
      active_region_height[3:0]  = regs[0][4][7:4];
      active_region_height[11:4] = regs[0][5];
      hsync_width_setting        = regs[0][6];
      vsync_width_setting        = regs[0][7];
      hback_porch_setting        = regs[0][8];
      vback_porch_setting        = regs[0][9];
   end

   ////////////////////////////////////////////////////////////////////////
   // Raster. Line layout: active, front porch, sync, back porch.
   tpg_state_e state;
   tpg_state_e next_state;
   tpg_dim_t   tw, th, aw, ah, hs, vs, hb, vb;
   tpg_dim_t   next_tw, next_th, next_aw, next_ah;
   tpg_dim_t   next_hs, next_vs, next_hb, next_vb;
   tpg_dim_t   hcnt, vcnt, next_hcnt, next_vcnt;
   logic       next_hsync, next_vsync, next_hblank, next_vblank, next_de;
   tpg_dim_t   hsync_start, hsync_end, vsync_start, vsync_end;
   logic       line_end, frame_end;

   always_comb begin
      hsync_start = tw - hs - hb;
      hsync_end   = tw - hb;
      vsync_start = th - vs - vb;
      vsync_end   = th - vb;
      line_end    = (hcnt == tw - `TPG_ONE12);
      frame_end   = line_end && (vcnt == th - `TPG_ONE12);
      next_state  = state;
      next_hcnt   = hcnt;
      next_vcnt   = vcnt;
      next_tw = tw;
      next_th = th;
      next_aw = aw;
      next_ah = ah;
      next_hs = hs;
      next_vs = vs;
      next_hb = hb;
      next_vb = vb;
      case (state)
         TPG_OFF: begin
            next_hcnt = `TPG_ZERO12;
            next_vcnt = `TPG_ZERO12;
            if (gen_enable) begin
               next_state = TPG_RUN;
               next_tw = frame_total_width;
               next_th = frame_total_height;
               next_aw = active_region_width;
               next_ah = active_region_height;
               next_hs = {4'h0, hsync_width_setting};
               next_vs = {4'h0, vsync_width_setting};
               next_hb = {4'h0, hback_porch_setting};
               next_vb = {4'h0, vback_porch_setting};
            end
         end
         TPG_RUN: begin
            if (!gen_enable) begin
               next_state = TPG_OFF;
               next_hcnt  = `TPG_ZERO12;
               next_vcnt  = `TPG_ZERO12;
            end else if (frame_end) begin
               next_hcnt = `TPG_ZERO12;
               next_vcnt = `TPG_ZERO12;
               next_tw = frame_total_width;
               next_th = frame_total_height;
               next_aw = active_region_width;
               next_ah = active_region_height;
               next_hs = {4'h0, hsync_width_setting};
               next_vs = {4'h0, vsync_width_setting};
               next_hb = {4'h0, hback_porch_setting};
               next_vb = {4'h0, vback_porch_setting};
            end else if (line_end) begin
               next_hcnt = `TPG_ZERO12;
               next_vcnt = vcnt + `TPG_ONE12;
            end else begin
               next_hcnt = hcnt + `TPG_ONE12;
            end
         end
         default: begin
            next_state = TPG_OFF;
            next_hcnt  = `TPG_ZERO12;
            next_vcnt  = `TPG_ZERO12;
         end
      endcase
      next_hsync  = (state == TPG_RUN) && (next_state == TPG_RUN)
                    && (next_hcnt >= hsync_start) && (next_hcnt < hsync_end);
      next_vsync  = (state == TPG_RUN) && (next_state == TPG_RUN)
                    && (next_vcnt >= vsync_start) && (next_vcnt < vsync_end);
      next_hblank = (next_state == TPG_RUN) && (next_hcnt >= next_aw);
      next_vblank = (next_state == TPG_RUN) && (next_vcnt >= next_ah);
      next_de     = (next_state == TPG_RUN) && (next_hcnt < next_aw)
                    && (next_vcnt < next_ah);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state  <= TPG_OFF;
         tw     <= `TPG_ZERO12;
         th     <= `TPG_ZERO12;
         aw     <= `TPG_ZERO12;
         ah     <= `TPG_ZERO12;
         hs     <= `TPG_ZERO12;
         vs     <= `TPG_ZERO12;
         hb     <= `TPG_ZERO12;
         vb     <= `TPG_ZERO12;
         hcnt   <= `TPG_ZERO12;
         vcnt   <= `TPG_ZERO12;
         hsync  <= 1'b0;
         vsync  <= 1'b0;
         hblank <= 1'b0;
         vblank <= 1'b0;
         de     <= 1'b0;
         pix_x  <= `TPG_ZERO12;
         line_y <= `TPG_ZERO12;
      end else begin
         state  <= next_state;
         tw     <= next_tw;
         th     <= next_th;
         aw     <= next_aw;
         ah     <= next_ah;
         hs     <= next_hs;
         vs     <= next_vs;
         hb     <= next_hb;
         vb     <= next_vb;
         hcnt   <= next_hcnt;
         vcnt   <= next_vcnt;
         hsync  <= next_hsync;
         vsync  <= next_vsync;
         hblank <= next_hblank;
         vblank <= next_vblank;
         de     <= next_de;
         pix_x  <= next_hcnt;
         line_y <= next_vcnt;
      end
   end

endmodule

// *** testbench/tpg_frame_timing_sva.sv ***
// Purpose: Port-level checks of the frame timing block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Settings are not mirrored, so checks tie outputs to each other.
`timescale 1ns/1ps
module tpg_frame_timing_sva (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [1:0]  port_sel,
   input wire logic [7:0]  indirect_offset_reg,
   input wire logic        data_wr,
   input wire logic [7:0]  data_wdata,
   input wire logic [7:0]  indirect_data_reg,
   input wire logic        gen_enable,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic        hblank,
   input wire logic        vblank,
   input wire logic        de,
   input wire logic [11:0] pix_x,
   input wire logic [11:0] line_y
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   de_blank_a: assert property (de |-> !hblank && !vblank)
      else $error("Display enable seen during blanking.");
   gen_off_a: assert property (!gen_enable [*2] |=> !de && !hsync &&
      !vsync && pix_x == 12'h000 && line_y == 12'h000)
      else $error("Raster outputs active while generator off.");
   pix_step_a: assert property (pix_x != 12'h000 |->
      pix_x == $past(pix_x) + 12'h001) else $error("Pixel count skipped.");
   line_step_a: assert property ($changed(line_y) && line_y != 12'h000 |->
      pix_x == 12'h000 && line_y == $past(line_y) + 12'h001)
      else $error("Line count moved off the line start.");
   vsync_edge_a: assert property ($changed(vsync) && gen_enable &&
      $past(gen_enable) |-> pix_x == 12'h000)
      else $error("Vertical sync changed inside a line.");
   hsync_porch_a: assert property ($fell(hsync) && gen_enable |->
      hblank && !de) else $error("No back porch after horizontal sync.");
   de_start_a: assert property ($rose(de) |-> pix_x == 12'h000)
      else $error("Active region started off pixel zero.");
   unmapped_zero_a: assert property (port_sel != 2'b00 &&
      (indirect_offset_reg < 8'h04 || indirect_offset_reg > 8'h0D)
      |=> indirect_data_reg == 8'h00) else $error("Unmapped read not zero.");
   rd_hold_a: assert property ($past(rstn) && $stable(port_sel) &&
      $stable(indirect_offset_reg) && !data_wr && !$past(data_wr)
      |=> $stable(indirect_data_reg)) else $error("Read data drifted.");
endmodule
bind tpg_frame_timing tpg_frame_timing_sva u_sva (.clk(clk), .rstn(rstn),
   .port_sel(port_sel), .indirect_offset_reg(indirect_offset_reg),
   .data_wr(data_wr), .data_wdata(data_wdata), .gen_enable(gen_enable),
   .indirect_data_reg(indirect_data_reg), .hsync(hsync), .vsync(vsync),
   .hblank(hblank), .vblank(vblank), .de(de), .pix_x(pix_x),
   .line_y(line_y));

// *** testbench/tpg_frame_timing_bench.sv ***
// Purpose: Self-checking bench for the frame timing block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   A byte model and a raster model give every expected value.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tpg_frame_timing_bench;
   import tpg_pkg::*;
   logic        clk = 0, rstn = 0, data_wr = 0, gen_enable = 0;
   logic        hs, vs, hb, vb, de;
   logic [1:0]  sel = 2'b01;
   logic [7:0]  ofs = 8'h00, wd = 8'h00, rd;
   logic [11:0] px, ly;
   int          error_cnt = 0, n_compared = 0, bank[2][256], p, o, h, v;
   int rv[10] = '{8'h48, 8'h53, 8'h1E, 8'h20, 8'h03, 8'h1E, 8'h0A, 8'h02,
                  8'h0A, 8'h02};
   // Frame of 261 by 20 with active 256 by 17, all syncs and back porches 1, front porches 3 and 1.
   int cfg[10] = '{8'h05, 8'h41, 8'h01, 8'h00, 8'h11, 8'h01, 1, 1, 1, 1};
   int tw = 261, th = 20, aw = 256, ah = 17, hsw = 1, vsw = 1, hbp = 1;
   int vbp = 1;
   always #20 clk = ~clk;
   tpg_frame_timing DUT (.clk(clk), .rstn(rstn), .port_sel(sel),
      .indirect_offset_reg(ofs), .data_wr(data_wr), .data_wdata(wd),
      .indirect_data_reg(rd), .gen_enable(gen_enable), .hsync(hs),
      .vsync(vs), .hblank(hb), .vblank(vb), .de(de), .pix_x(px),
      .line_y(ly));
   task automatic summarize();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] s, input int a, input int d);
      @(negedge clk);
      sel = s;
      ofs = a[7:0];
      wd = d[7:0];
      data_wr = 1;
      for (int i = 0; i < 2; i++) if (s[i] && a >= 4 && a <= 13) bank[i][a] = d;
      @(negedge clk);
      data_wr = 0;
   endtask
   // Port 0 wins a read when both ports are selected.
   task automatic rdc(input logic [1:0] s, input int a);
      @(negedge clk);
      sel = s;
      ofs = a[7:0];
      repeat (2) @(negedge clk);
      `CHK(rd, 8'(bank[s[0] ? 0 : 1][a]))
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(45));
      for (o = 4; o < 14; o++) begin
         bank[0][o] = rv[o-4];
         bank[1][o] = rv[o-4];
      end
      repeat (10) @(posedge clk);
      @(negedge clk);
      rstn = 1;
      for (p = 1; p < 3; p++) for (o = 0; o < 16; o++) rdc(p[1:0], o);
      repeat (30) begin
         p = $urandom_range(1, 3);
         o = $urandom_range(0, 20);
         wr(p[1:0], o, $urandom_range(0, 255));
         rdc(p[1:0], o);
      end
      for (o = 4; o < 14; o++) wr(2'b01, o, cfg[o-4]);
      @(negedge clk);
      gen_enable = 1;
      @(posedge clk);
      for (v = 0; v < th; v++) for (h = 0; h < tw; h++) begin
         @(negedge clk);
         `CHK(px, 12'(h))
         `CHK(ly, 12'(v))
         `CHK(de, logic'(h < aw && v < ah))
         `CHK(hb, logic'(h >= aw))
         `CHK(vb, logic'(v >= ah))
         `CHK(hs, logic'(h >= tw - hsw - hbp && h < tw - hbp))
         `CHK(vs, logic'(v >= th - vsw - vbp && v < th - vbp))
      end
      @(negedge clk);
      `CHK(px, 12'h000)
      gen_enable = 0;
      repeat (3) @(negedge clk);
      `CHK({de, hs, vs}, 3'b000)
      summarize();
   end
endmodule
